// ### src/fsc_regs.v
// flash security, test-mode and configuration register bank
//
// Operation
// R1 - lock-status readable, writes ignored
// R2 - lock-status loaded from byte ff0f at reset
// R3 - backdoor enabled only when key field 10
// R4 - reserved nonvolatile bits stay erased one
// R5 - unsecured only when lock field 10
// R6 - backdoor unlock forces lock field 10
// R7 - test-mode reads zero, unwritable in normal
// R8 - write-all-banks writable only in special mode
// R9 - write-all-banks writes every bank copy
// R10 - config: four bits rw, rest zero
// R11 - key-access writable only when key enabled
// R12 - buffer-empty interrupt gated by bit 7
// R13 - command-done interrupt gated by bit 6
// R14 - key-access routes array writes as keys
// R15 - bank-select picks block 0 or 1
// R16 - these registers are unbanked, shared
// R17 - status flags: bit 7 empty, 6 done
// R18 - interrupt requests are level, flag and enable
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_regs #(
  parameter AW = 4
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst_b,
  // register port
  input  wire [AW-1:0] reg_addr,
  input  wire [7:0]    reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [7:0]    reg_rdata_q,
  // nonvolatile load from the array at reset
  input  wire          nv_load,
  input  wire [7:0]    nv_cfg_byte,
  output reg  [15:0]   nv_addr_q,
  // mode pin, from outside the clock domain
  input  wire          special_mode,
  // command sequencer status and unlock event
  input  wire          buffer_empty_flag,
  input  wire          command_done_flag,
  input  wire          backdoor_unlock,
  // array access steering
  input  wire          array_wr,
  input  wire          array_rd,
  output reg           array_cmd_wr_q,
  output reg           array_key_wr_q,
  output reg           array_rd_invalid_q,
  // bank and banked register copies (sample banked register)
  output reg           bank_select_q,
  output reg           bank_wr0_q,
  output reg           bank_wr1_q,
  output reg  [7:0]    banked_rdata_q,
  // interrupt requests
  output reg           buffer_empty_irq_q,
  output reg           command_done_irq_q
);
  // ============================================================
  // declarations
  reg  [7:0] lock_status_q;      // security byte copy
  reg        write_all_banks_q;  // test-mode bit
  reg        be_ie_q;            // buffer-empty enable
  reg        cd_ie_q;            // command-done enable
  reg        key_write_access_q; // backdoor key gate
  reg        mode_s1_q;          // synchroniser stage 1
  reg        mode_s2_q;          // synchroniser stage 2
  reg  [7:0] rd_d;               // read mux
  wire       key_en;             // backdoor enabled
  wire       wr_test;
  wire       wr_cfg;
  wire       wr_bank;
  wire       bank_we0;
  wire       bank_we1;
  wire [7:0] bank0_val;
  wire [7:0] bank1_val;
  wire [7:0] status_byte;

  // ============================================================
  // decode
  // R3 - key enable decode
  assign key_en  = (lock_status_q[`FSC_BACKDOOR_KEY_ENABLE_HI:`FSC_BACKDOOR_KEY_ENABLE_LO]
                    == `FSC_BACKDOOR_KEY_ENABLE_ON);
  assign wr_test = reg_wr && (reg_addr == `FSC_OFF_TEST_MODE);
  assign wr_cfg  = reg_wr && (reg_addr == `FSC_OFF_CONFIG);
  // banked register shares the status offset in this model
  assign wr_bank = reg_wr && (reg_addr == `FSC_OFF_STATUS);
  // R9 - write-all-banks fan-out
  assign bank_we0 = wr_bank && (write_all_banks_q || !bank_select_q);
  assign bank_we1 = wr_bank && (write_all_banks_q || bank_select_q);

  // R17 - status flag positions
  assign status_byte = {buffer_empty_flag, command_done_flag, 6'h00};

  // ============================================================
  // mode pin synchroniser
  // second stage alone feeds logic
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end
    else
    begin
      mode_s1_q <= special_mode;
      mode_s2_q <= mode_s1_q;
    end
  end

  // ============================================================
  // lock-status register
  // reset value is all ones (erased), i.e. secured until loaded
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lock_status_q <= `FSC_LOCK_RST;
    end
    else if (nv_load)
    begin
      // R2 - nonvolatile load
      lock_status_q <= nv_cfg_byte;
    end
    else if (backdoor_unlock)
    begin
      // R6 - force unsecured
      lock_status_q[`FSC_LOCK_HI:`FSC_LOCK_LO] <= `FSC_LOCK_OPEN;
    end
    // R1 - no bus write path reaches this register
  end

  // ============================================================
  // test-mode register
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      write_all_banks_q <= 1'b0;
    end
    else if (!mode_s2_q)
    begin
      // R7 - normal mode clears it
      write_all_banks_q <= 1'b0;
    end
    else if (wr_test)
    begin
      // R8 - special mode write
      write_all_banks_q <= reg_wdata[`FSC_WRITE_ALL_BANKS_BIT];
    end
  end

  // ============================================================
  // configuration register, single instance
  // R16 - unbanked config
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      be_ie_q            <= 1'b0;
      cd_ie_q            <= 1'b0;
      key_write_access_q <= 1'b0;
      bank_select_q      <= 1'b0;
    end
    else if (wr_cfg)
    begin
      // R10 - four writable bits
      be_ie_q       <= reg_wdata[`FSC_BE_IE_BIT];
      cd_ie_q       <= reg_wdata[`FSC_CD_IE_BIT];
      // R15 - bank select
      bank_select_q <= reg_wdata[`FSC_BANK_SELECT_BIT];
      // R11 - key gate writable
      if (key_en)
      begin
        key_write_access_q <= reg_wdata[`FSC_KEY_WRITE_ACCESS_BIT];
      end
    end
  end

  // ============================================================
  // banked register copies, one per flash block
  fsc_bank_reg #(
    .WIDTH (8),
    .RST   (8'h00)
  ) u_bank0 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr_en   (bank_we0),
    .wr_data (reg_wdata),
    .val_q   (bank0_val)
  );

  fsc_bank_reg #(
    .WIDTH (8),
    .RST   (8'h00)
  ) u_bank1 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr_en   (bank_we1),
    .wr_data (reg_wdata),
    .val_q   (bank1_val)
  );

  // ============================================================
  // read mux
  always @*
  begin
    rd_d = 8'h00;
    case (reg_addr)
      // R5 - lock field read back as held
      `FSC_OFF_LOCK_STATUS: rd_d = lock_status_q;
      // R7 - zero in normal mode
      `FSC_OFF_TEST_MODE:
      begin
        rd_d = 8'h00;
        if (mode_s2_q)
        begin
          rd_d[`FSC_WRITE_ALL_BANKS_BIT] = write_all_banks_q;
        end
      end
      `FSC_OFF_CONFIG:
      begin
        rd_d[`FSC_BE_IE_BIT]  = be_ie_q;
        rd_d[`FSC_CD_IE_BIT]  = cd_ie_q;
        rd_d[`FSC_KEY_WRITE_ACCESS_BIT] = key_write_access_q;
        rd_d[`FSC_BANK_SELECT_BIT]  = bank_select_q;
      end
      `FSC_OFF_STATUS: rd_d = status_byte;
      // unmapped reads zero
      default: rd_d = 8'h00;
    endcase
  end

  // ============================================================
  // registered outputs
  // read data stands one cycle after the strobe only
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata_q        <= 8'h00;
      nv_addr_q          <= 16'h0000;
      array_cmd_wr_q     <= 1'b0;
      array_key_wr_q     <= 1'b0;
      array_rd_invalid_q <= 1'b0;
      bank_wr0_q         <= 1'b0;
      bank_wr1_q         <= 1'b0;
      banked_rdata_q     <= 8'h00;
      buffer_empty_irq_q <= 1'b0;
      command_done_irq_q <= 1'b0;
    end
    else
    begin
      reg_rdata_q    <= reg_rd ? rd_d : 8'h00;
      nv_addr_q      <= `FSC_NV_CFG_ADDR;
      // R14 - array write steering
      array_cmd_wr_q <= array_wr && !key_write_access_q;
      array_key_wr_q <= array_wr && key_write_access_q;
      array_rd_invalid_q <= array_rd && key_write_access_q;
      bank_wr0_q     <= bank_we0;
      bank_wr1_q     <= bank_we1;
      banked_rdata_q <= bank_select_q ? bank1_val : bank0_val;
      // R12 - buffer-empty request
      // R18 - level request
      buffer_empty_irq_q <= be_ie_q && buffer_empty_flag;
      // R13 - command-done request
      command_done_irq_q <= cd_ie_q && command_done_flag;
    end
  end
endmodule // fsc_regs
`default_nettype wire

// ### common/fsc_defines.vh
// constants for the flash security and configuration register bank
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
// ============================================================
// register offsets (byte addresses on the register port)
`define FSC_OFF_LOCK_STATUS   4'h1
`define FSC_OFF_TEST_MODE     4'h2
`define FSC_OFF_CONFIG        4'h3
`define FSC_OFF_STATUS        4'h5
// ============================================================
// nonvolatile configuration byte address in the array
`define FSC_NV_CFG_ADDR       16'hff0f
// ============================================================
// lock-status field positions
`define FSC_BACKDOOR_KEY_ENABLE_HI          7
`define FSC_BACKDOOR_KEY_ENABLE_LO          6
`define FSC_LOCK_HI           1
`define FSC_LOCK_LO           0
`define FSC_BACKDOOR_KEY_ENABLE_ON          2'h2
`define FSC_LOCK_OPEN         2'h2
// ============================================================
// test-mode and config field positions
`define FSC_WRITE_ALL_BANKS_BIT         4
`define FSC_BE_IE_BIT         7
`define FSC_CD_IE_BIT         6
`define FSC_KEY_WRITE_ACCESS_BIT        5
`define FSC_BANK_SELECT_BIT         0
// status flag positions
`define FSC_BE_FLAG_BIT       7
`define FSC_CD_FLAG_BIT       6
// ============================================================
// reset values
`define FSC_CONFIG_RST        8'h00
`define FSC_LOCK_RST          8'hff
`endif

// ### src/fsc_bank_reg.v
// one copy of a banked register, instanced once per flash block
`timescale 1ns/1ps
`default_nettype none
module fsc_bank_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RST = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst_b,
  // write side
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  // stored value
  output reg  [WIDTH-1:0] val_q
);
  // ============================================================
  // storage
  // plain write-enabled register
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      val_q <= RST;
    end
    else if (wr_en)
    begin
      val_q <= wr_data;
    end
  end
endmodule // fsc_bank_reg
`default_nettype wire

// ### bench/fsc_regs_asserts.sv
// checker for the flash security and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module fsc_regs_chk #(
  parameter AW = 4
) (
  // clock, reset and register port
  input wire logic          sys_clk,
  input wire logic          rst_b,
  input wire logic [AW-1:0] reg_addr,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_rdata_q,
  input wire logic          special_mode,
  // status flags and requests
  input wire logic          buffer_empty_flag,
  input wire logic          command_done_flag,
  input wire logic          buffer_empty_irq_q,
  input wire logic          command_done_irq_q,
  // array steering
  input wire logic          array_wr,
  input wire logic          array_rd,
  input wire logic          array_cmd_wr_q,
  input wire logic          array_key_wr_q,
  input wire logic          array_rd_invalid_q,
  input wire logic [15:0]   nv_addr_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_cfg_byte_addr: assert property ($past(rst_b) |-> nv_addr_q == 16'hff0f)
    else $error("config byte address wrong");
  // four quiet cycles cover the two-flop mode sync
  a_test_normal: assert property ((!special_mode)[*4] ##0
    (reg_rd && reg_addr == 4'h2) |=> reg_rdata_q == 8'h00)
    else $error("test-mode read not zero");
  a_cfg_gaps: assert property (reg_rd && reg_addr == 4'h3
    |=> reg_rdata_q[4:1] == 4'h0) else $error("config gap bits set");
  a_status_empty: assert property (reg_rd && reg_addr == 4'h5
    |=> reg_rdata_q[7] == $past(buffer_empty_flag))
    else $error("status bit 7 wrong");
  a_be_gate: assert property (!buffer_empty_flag |=> !buffer_empty_irq_q)
    else $error("empty request without flag");
  a_cd_gate: assert property (!command_done_flag |=> !command_done_irq_q)
    else $error("done request without flag");
  a_array_route: assert property (array_wr
    |=> array_cmd_wr_q != array_key_wr_q) else $error("array write misrouted");
  a_rd_quiet: assert property (!array_rd |=> !array_rd_invalid_q)
    else $error("invalid read without read");
  c_key_wr: cover property (array_key_wr_q);
  c_be_irq: cover property (buffer_empty_irq_q && command_done_irq_q);
  c_rd_inv: cover property (array_rd_invalid_q);
endmodule // fsc_regs_chk
bind fsc_regs fsc_regs_chk #(.AW(AW)) u_chk (.*);
`default_nettype wire

// ### bench/fsc_flash_model.sv
// flash-side model: config byte load and backdoor key counting
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
  parameter KEYS = 4
) (
  // clock, reset and bench control
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       reload,
  input  wire logic [1:0] key_en,
  input  wire logic [1:0] lock_code,
  // device side
  input  wire logic       array_key_wr_q,
  output var  logic       nv_load,
  output wire logic [7:0] nv_cfg_byte,
  output var  logic       backdoor_unlock
);
  logic       first_q; // load still owed after reset
  logic [2:0] cnt_q;   // keys taken since the last unlock
  // reserved bits erased
  // byte only valid with the load pulse, inverted otherwise
  assign nv_cfg_byte = nv_load ? {key_en, 4'hf, lock_code}
                               : ~{key_en, 4'hf, lock_code};
  // load pulse and key counting
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      first_q         <= 1'b1;
      nv_load         <= 1'b0;
      cnt_q           <= 3'h0;
      backdoor_unlock <= 1'b0;
    end
    else
    begin
      first_q         <= 1'b0;
      nv_load         <= first_q | reload;
      backdoor_unlock <= array_key_wr_q && cnt_q == 3'(KEYS - 1);
      if (array_key_wr_q)
        cnt_q <= (cnt_q == 3'(KEYS - 1)) ? 3'h0 : cnt_q + 3'h1;
    end
endmodule // fsc_flash_model
`default_nettype wire

// ### bench/fsc_regs_tb.sv
// self-checking bench for the flash security register bank
`timescale 1ns/1ps
`default_nettype none
module fsc_regs_tb;
  logic        sys_clk, rst_b, reg_wr, reg_rd, nv_load, special_mode;
  logic        buffer_empty_flag, command_done_flag, backdoor_unlock;
  logic        array_wr, array_rd, array_cmd_wr_q, array_key_wr_q;
  logic        array_rd_invalid_q, bank_select_q, bank_wr0_q, bank_wr1_q;
  logic        buffer_empty_irq_q, command_done_irq_q, reload;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q, nv_cfg_byte, banked_rdata_q, rv;
  logic [15:0] nv_addr_q;
  logic [1:0]  key_en, lock_code;
  int          num_errors, total_checks;
  fsc_regs uut (.*);
  fsc_flash_model #(.KEYS(4)) u_flash (.*);
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata_q;
    chk(rv, exp);
  endtask
  task automatic pa(input logic w);
    @(posedge sys_clk);
    array_wr <= w; array_rd <= !w;
    @(posedge sys_clk);
    array_wr <= 1'b0; array_rd <= 1'b0;
    #1;
  endtask
  task automatic load(input logic [1:0] k, input logic [1:0] l);
    @(posedge sys_clk);
    key_en <= k; lock_code <= l; reload <= 1'b1;
    @(posedge sys_clk);
    reload <= 1'b0;
    wt(3);
  endtask
  task automatic irq(input logic [7:0] exp);
    wt(2);
    chk({6'h0, buffer_empty_irq_q, command_done_irq_q}, exp);
  endtask
  // key-enable codes, with the enabled one last
  task automatic t_codes();
    int c;
    for (int i = 0; i < 4; i++)
    begin
      c = (i + 3) % 4;
      load(2'(c), 2'(3 - c));
      rc(4'h1, {2'(c), 4'hf, 2'(3 - c)});
      wr(4'h1, 8'h00);
      rc(4'h1, {2'(c), 4'hf, 2'(3 - c)});
      wr(4'h3, 8'h20);
      rc(4'h3, (c == 2) ? 8'h20 : 8'h00);
    end
  endtask
  task automatic t_config();
    wr(4'h3, 8'hff);
    rc(4'h3, 8'he1);
    @(posedge sys_clk);
    buffer_empty_flag <= 1'b1; command_done_flag <= 1'b1;
    irq(8'h03);
    rc(4'h5, 8'hc0);
    wr(4'h3, 8'h40);
    irq(8'h01);
    @(posedge sys_clk);
    command_done_flag <= 1'b0;
    irq(8'h00);
    rc(4'h5, 8'h80);
    wr(4'h3, 8'h80);
    irq(8'h02);
    @(posedge sys_clk);
    buffer_empty_flag <= 1'b0;
    irq(8'h00);
  endtask
  // command path, then key path up to unlock
  task automatic t_array();
    wr(4'h3, 8'h00);
    pa(1'b1);
    chk({6'h0, array_cmd_wr_q, array_key_wr_q}, 8'h02);
    pa(1'b0);
    chk({7'h0, array_rd_invalid_q}, 8'h00);
    load(2'h2, 2'h1);
    wr(4'h3, 8'h20);
    pa(1'b0);
    chk({7'h0, array_rd_invalid_q}, 8'h01);
    repeat (4)
    begin
      pa(1'b1);
      chk({6'h0, array_cmd_wr_q, array_key_wr_q}, 8'h01);
    end
    for (int i = 0; i < 20 && backdoor_unlock !== 1'b1; i++) wt(1);
    if (backdoor_unlock !== 1'b1)
    begin
      num_errors++;
      stop_test();
    end
    wt(2);
    rc(4'h1, 8'hbe);
    wr(4'h3, 8'h00);
  endtask
  task automatic t_banks();
    wr(4'h2, 8'h10);
    rc(4'h2, 8'h00);
    wr(4'h5, 8'h5a);
    wt(0);
    chk({6'h0, bank_wr1_q, bank_wr0_q}, 8'h01);
    wt(2);
    chk(banked_rdata_q, 8'h5a);
    wr(4'h3, 8'h01);
    wr(4'h5, 8'hc3);
    wt(0);
    chk({6'h0, bank_wr1_q, bank_wr0_q}, 8'h02);
    irq(8'h00);
    chk(banked_rdata_q, 8'hc3);
    rc(4'h3, 8'h01);
    wr(4'h3, 8'h00);
    wt(2);
    chk(banked_rdata_q, 8'h5a);
    @(posedge sys_clk);
    special_mode <= 1'b1;
    wt(3);
    wr(4'h2, 8'h10);
    rc(4'h2, 8'h10);
    wr(4'h5, 8'h77);
    wt(0);
    chk({6'h0, bank_wr1_q, bank_wr0_q}, 8'h03);
    wr(4'h3, 8'h01);
    wt(2);
    chk(banked_rdata_q, 8'h77);
    @(posedge sys_clk);
    special_mode <= 1'b0;
    wt(3);
    rc(4'h2, 8'h00);
    rc(4'hf, 8'h00);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rst_b, reg_wr, reg_rd, special_mode, reload} = 5'h00;
    {buffer_empty_flag, command_done_flag, array_wr, array_rd} = 4'h0;
    {reg_addr, reg_wdata, key_en, lock_code} = 16'h00d;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    wt(4);
    rc(4'h1, 8'hfd);
    t_codes();
    t_config();
    t_array();
    t_banks();
    stop_test();
  end
endmodule // fsc_regs_tb
`default_nettype wire
